// *** src/uiv_validator.sv ***
// Update image validator: walks an image in memory and reports pass or fail,
// and serves the read-only platform identification register.
// Assumes memory answers on the same clock; platform field arrives from pins.
`timescale 1ns/1ps
module uiv_validator
    import uiv_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_start,
    input  wire logic [31:0] i_cpu_signature,
    input  wire logic [2:0]  i_platform_field,
    output logic             o_mem_req,
    output logic [31:0]      o_mem_addr,
    input  wire logic        i_mem_ack,
    input  wire logic [31:0] i_mem_data,
    output logic             o_pass,
    output logic             o_fail,
    input  wire logic        i_msr_rd,
    input  wire logic [31:0] i_msr_addr,
    output logic             o_msr_ack,
    output logic             o_msr_err,
    output logic [63:0]      o_msr_rdata
);

    localparam logic [31:0] WRD_VERSION = OFS_VERSION >> WORD_SHIFT;
    localparam logic [31:0] WRD_SIG     = OFS_SIGNATURE >> WORD_SHIFT;
    localparam logic [31:0] WRD_FLAGS   = OFS_FLAGS >> WORD_SHIFT;
    localparam logic [31:0] WRD_TSIZE   = OFS_TOTAL_SIZE >> WORD_SHIFT;
    localparam logic [31:0] WRD_DSIZE   = OFS_DATA_SIZE >> WORD_SHIFT;

    typedef struct packed {
        uiv_state_type state;
        logic          mem_req;
        logic [31:0]   mem_addr;
        logic [31:0]   idx;
        logic [31:0]   nwords;
        logic [31:0]   sum;
        logic [31:0]   sig;
        logic [31:0]   flags;
        logic [31:0]   tsize;
        logic [31:0]   dsize;
        logic [31:0]   ext_len;
        logic [1:0]    pos;
        logic          ext_hit;
        logic          take;
        logic [31:0]   ext_flags;
        logic          pass;
        logic          fail;
        logic          msr_ack;
        logic          msr_err;
        logic [63:0]   msr_rdata;
        logic [2:0]    plat_s1;
        logic [2:0]    plat_s2;
    } uiv_regs_type;

    uiv_regs_type st;
    uiv_regs_type next_st;
    logic [31:0]  sum_add;
    logic [7:0]   plat_mask;
    logic [63:0]  plat_reg;
    logic         prim_ok;
    logic         ext_ok;
    logic         ext_entry;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        next_st   = st;
        // Unsigned wrap-around is exactly the required modulo sum
        sum_add   = st.sum + i_mem_data;
        plat_mask = FLAG_ONE << st.plat_s2;
        prim_ok   = |(st.flags[FLAG_BITS-1:0] & plat_mask);
        ext_ok    = |(st.ext_flags[FLAG_BITS-1:0] & plat_mask);
        ext_entry = (st.idx >= EXT_HDR_WORDS);
        plat_reg  = '0;
        plat_reg[PLAT_LSB +: PLAT_W] = st.plat_s2;

        // Platform field comes from pins, so it is synchronised first
        next_st.plat_s1 = i_platform_field;
        next_st.plat_s2 = st.plat_s1;

        next_st.msr_ack = 1'b0;
        next_st.msr_err = 1'b0;
        if (i_msr_rd) begin
            if (i_msr_addr == MSR_PLAT_ADDR) begin
                next_st.msr_ack   = 1'b1;
                next_st.msr_rdata = plat_reg;
            end else begin
                next_st.msr_err = 1'b1;
            end
        end

        unique case (st.state)
            ST_IDLE: begin
                if (i_start) begin
                    next_st.state    = ST_IMG;
                    next_st.pass     = 1'b0;
                    next_st.fail     = 1'b0;
                    next_st.mem_req  = 1'b1;
                    next_st.mem_addr = '0;
                    next_st.idx      = '0;
                    next_st.sum      = '0;
                    // Stays huge until the size words have been seen
                    next_st.nwords   = '1;
                end
            end
            ST_IMG: begin
                if (i_mem_ack) begin
                    next_st.sum      = sum_add;
                    next_st.idx      = st.idx + 32'h0000_0001;
                    next_st.mem_addr = st.mem_addr + WORD_BYTES;
                    if (st.idx == WRD_SIG) begin
                        next_st.sig = i_mem_data;
                    end
                    if (st.idx == WRD_FLAGS) begin
                        next_st.flags = i_mem_data;
                    end
                    if (st.idx == WRD_TSIZE) begin
                        next_st.tsize = i_mem_data;
                    end
                    if (st.idx == WRD_DSIZE) begin
                        next_st.dsize = i_mem_data;
                        if (i_mem_data == '0) begin
                            next_st.nwords = DEFAULT_WORDS;
                        end else begin
                            next_st.nwords = st.tsize >> WORD_SHIFT;
                        end
                    end
                    if (st.idx == st.nwords - 32'h0000_0001) begin
                        next_st.state   = ST_IDLE;
                        next_st.mem_req = 1'b0;
                        if (sum_add != SUM_GOOD) begin
                            next_st.fail = 1'b1;
                        end else if (st.sig == i_cpu_signature) begin
                            next_st.pass = prim_ok;
                            next_st.fail = !prim_ok;
                        end else if (st.tsize > st.dsize + EXT_COUNT_OFS) begin
                            // A table is walked only if the total size leaves room past the data; without that room the image fails
                            next_st.state    = ST_EXT;
                            next_st.mem_req  = 1'b1;
                            next_st.mem_addr = st.dsize + EXT_COUNT_OFS;
                            next_st.idx      = '0;
                            next_st.sum      = '0;
                            next_st.ext_len  = '1;
                            next_st.pos      = POS_SIG;
                            next_st.ext_hit  = 1'b0;
                            next_st.take     = 1'b0;
                        end else begin
                            next_st.fail = 1'b1;
                        end
                    end
                    // A foreign header version is never summed to the end
                    if (st.idx == WRD_VERSION && i_mem_data != HDR_VERSION_1) begin
                        next_st.state   = ST_IDLE;
                        next_st.mem_req = 1'b0;
                        next_st.pass    = 1'b0;
                        next_st.fail    = 1'b1;
                    end
                end
            end
            ST_EXT: begin
                if (i_mem_ack) begin
                    next_st.sum      = sum_add;
                    next_st.idx      = st.idx + 32'h0000_0001;
                    next_st.mem_addr = st.mem_addr + WORD_BYTES;
                    if (st.idx == '0) begin
                        // Header words plus three per entry bound the walk
                        next_st.ext_len = 32'(EXT_HDR_WORDS + ENTRY_WORDS * i_mem_data);
                    end
                    if (ext_entry) begin
                        next_st.pos = (st.pos == POS_LAST) ? POS_SIG : st.pos + 2'h1;
                        if (st.pos == POS_SIG && !st.ext_hit
                                && i_mem_data == i_cpu_signature) begin
                            next_st.ext_hit = 1'b1;
                            next_st.take    = 1'b1;
                        end
                        if (st.pos == POS_FLAGS && st.take) begin
                            next_st.ext_flags = i_mem_data;
                            next_st.take      = 1'b0;
                        end
                    end
                    if (st.idx == st.ext_len - 32'h0000_0001) begin
                        next_st.state   = ST_IDLE;
                        next_st.mem_req = 1'b0;
                        next_st.pass    = (sum_add == SUM_GOOD) && st.ext_hit && ext_ok;
                        next_st.fail    = !((sum_add == SUM_GOOD) && st.ext_hit && ext_ok);
                    end
                end
            end
            default: begin
                next_st.state   = ST_IDLE;
                next_st.mem_req = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_mem_req   = st.mem_req;
    assign o_mem_addr  = st.mem_addr;
    assign o_pass      = st.pass;
    assign o_fail      = st.fail;
    assign o_msr_ack   = st.msr_ack;
    assign o_msr_err   = st.msr_err;
    assign o_msr_rdata = st.msr_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    sequence s_msr_good;
        i_msr_rd && (i_msr_addr == MSR_PLAT_ADDR);
    endsequence

    sequence s_msr_bad;
        i_msr_rd && (i_msr_addr != MSR_PLAT_ADDR);
    endsequence

    chk_msr_read_data: assert property (
        s_msr_good |=> o_msr_ack && !o_msr_err
            && o_msr_rdata[PLAT_LSB +: PLAT_W] == $past(st.plat_s2))
        else $error("platform register read answered wrongly");

    chk_msr_reserved_zero: assert property (
        o_msr_ack |-> o_msr_rdata[63:53] == '0 && o_msr_rdata[49:0] == '0)
        else $error("platform register reserved bits not zero");

    chk_msr_bad_addr: assert property (
        s_msr_bad |=> o_msr_err && !o_msr_ack)
        else $error("unmapped register address was acknowledged");

    chk_result_exclusive: assert property (
        !(o_pass && o_fail))
        else $error("pass and fail raised together");

    chk_version_reject: assert property (
        st.state == ST_IMG && i_mem_ack && st.idx == WRD_VERSION
            && i_mem_data != HDR_VERSION_1 |=> o_fail && !o_mem_req)
        else $error("foreign header version not rejected");

    chk_zero_size_len: assert property (
        st.state == ST_IMG && i_mem_ack && st.idx == WRD_DSIZE
            && i_mem_data == '0 |=> st.nwords == DEFAULT_WORDS)
        else $error("zero data size did not select default length");

    chk_total_size_len: assert property (
        st.state == ST_IMG && i_mem_ack && st.idx == WRD_DSIZE
            && i_mem_data != '0 |=> st.nwords == ($past(st.tsize) >> WORD_SHIFT))
        else $error("word count not taken from total size");

    chk_pass_needs_sum: assert property (
        $rose(o_pass) |-> $past(sum_add) == SUM_GOOD)
        else $error("pass raised with nonzero checksum");

    chk_ext_start_addr: assert property (
        st.state == ST_IMG ##1 st.state == ST_EXT
            |-> o_mem_addr == st.dsize + EXT_COUNT_OFS && o_mem_req)
        else $error("extended table fetched from wrong address");

    chk_ext_pass_hit: assert property (
        $past(st.state) == ST_EXT && $rose(o_pass) |-> $past(st.ext_hit))
        else $error("extended pass without signature match");

    chk_prim_platform: assert property (
        st.state == ST_IMG ##1 o_pass
            |-> $past((st.flags[FLAG_BITS-1:0] & plat_mask) != '0))
        else $error("primary pass without platform flag");

    sequence s_img_to_ext;
        st.state == ST_IMG ##1 st.state == ST_EXT;
    endsequence

    sequence s_prim_done;
        st.state == ST_IMG ##1 o_pass;
    endsequence

    sequence s_ext_done;
        st.state == ST_EXT ##1 o_pass;
    endsequence

    chk_msr_ack_pulse: assert property (
        !$past(i_msr_rd) |-> !o_msr_ack && !o_msr_err)
        else $error("register answer without a read strobe");

    chk_req_holds: assert property (
        o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr))
        else $error("memory request dropped or moved before ack");

    chk_dsize_capture: assert property (
        st.state == ST_IMG && i_mem_ack && st.idx == WRD_DSIZE
            |=> st.dsize == $past(i_mem_data))
        else $error("data size word not captured");

    chk_img_sum_step: assert property (
        st.state == ST_IMG && i_mem_ack
            |=> st.state == ST_EXT || st.sum == 32'($past(st.sum) + $past(i_mem_data)))
        else $error("image sum did not add the acked word");

    chk_ext_sum_step: assert property (
        st.state == ST_EXT && i_mem_ack
            |=> st.sum == 32'($past(st.sum) + $past(i_mem_data)))
        else $error("table sum did not add the acked word");

    chk_ext_needs_room: assert property (
        s_img_to_ext |-> st.tsize > st.dsize + EXT_COUNT_OFS)
        else $error("table walked although total size leaves no room");

    chk_ext_walk_len: assert property (
        st.state == ST_EXT && i_mem_ack && st.idx == '0
            |=> st.ext_len == 32'(EXT_HDR_WORDS + ENTRY_WORDS * $past(i_mem_data)))
        else $error("table walk length not taken from entry count");

    chk_ext_word_addr: assert property (
        st.state == ST_EXT
            |-> o_mem_addr == st.dsize + EXT_COUNT_OFS + (st.idx << WORD_SHIFT))
        else $error("table word fetched from wrong address");

    chk_entry_field_pos: assert property (
        st.state == ST_EXT && ext_entry
            |-> st.pos == 2'((st.idx - EXT_HDR_WORDS) % ENTRY_WORDS))
        else $error("entry field position out of step");

    chk_hit_sticky: assert property (
        st.state == ST_EXT && st.ext_hit |=> st.ext_hit)
        else $error("signature match lost during table walk");

    chk_first_match_kept: assert property (
        st.state == ST_EXT && st.ext_hit && !st.take |=> $stable(st.ext_flags))
        else $error("later entry overwrote first matching flags");

    chk_prim_sig_match: assert property (
        s_prim_done |-> st.sig == i_cpu_signature)
        else $error("primary pass without signature match");

    chk_ext_platform: assert property (
        s_ext_done |-> $past(ext_ok) && $past(st.ext_hit))
        else $error("table pass without entry platform flag");

    chk_result_when_idle: assert property (
        o_pass || o_fail |-> st.state == ST_IDLE && !o_mem_req)
        else $error("result shown while a walk is running");

endmodule // uiv_validator

// *** src/uiv_pkg.sv ***
// Constants, field layout and state codes for the update image validator.
// Assumes a single 100 MHz clock domain shared with the image memory port.
package uiv_pkg;
    localparam logic [31:0] OFS_VERSION    = 32'h0000_0000;
    localparam logic [31:0] OFS_SIGNATURE  = 32'h0000_000C;
    localparam logic [31:0] OFS_FLAGS      = 32'h0000_0018;
    localparam logic [31:0] OFS_TOTAL_SIZE = 32'h0000_001C;
    localparam logic [31:0] OFS_DATA_SIZE  = 32'h0000_0020;
    localparam logic [31:0] EXT_COUNT_OFS  = 32'h0000_0030;
    localparam logic [31:0] EXT_HDR_WORDS  = 32'h0000_0005;
    localparam logic [31:0] ENTRY_WORDS    = 32'h0000_0003;
    localparam logic [31:0] WORD_BYTES     = 32'h0000_0004;
    localparam logic [4:0]  WORD_SHIFT     = 5'h02;
    localparam logic [31:0] DEFAULT_WORDS  = 32'h0000_0200;
    localparam logic [31:0] HDR_VERSION_1  = 32'h0000_0001;
    localparam logic [31:0] SUM_GOOD       = 32'h0000_0000;
    localparam logic [31:0] MSR_PLAT_ADDR  = 32'h0000_0017;
    localparam int          PLAT_LSB       = 50;
    localparam int          PLAT_W         = 3;
    localparam int          FLAG_BITS      = 8;
    localparam logic [7:0]  FLAG_ONE       = 8'h01;
    localparam logic [1:0]  POS_SIG        = 2'h0;
    localparam logic [1:0]  POS_FLAGS      = 2'h1;
    localparam logic [1:0]  POS_LAST       = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_IMG  = 2'b01,
        ST_EXT  = 2'b10
    } uiv_state_type;
endpackage

// *** verif/uiv_mem_model.sv ***
// Image memory model that answers the validator's word requests.
// Assumes the validator holds request and address steady until acked.
`timescale 1ns/1ps
module uiv_mem_model (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_mem_req,
    input  wire logic [31:0] i_mem_addr,
    input  wire logic [3:0]  i_wait,
    output logic             o_mem_ack,
    output logic [31:0]      o_mem_data
);
    logic [31:0] mem [0:511];
    logic [3:0]  wait_cnt;
    logic [31:0] last_data;

    ////////////////////////////////////////////////////////////////////////////////
    // Each word waits i_wait cycles, so a slow setting stretches every transfer
    assign o_mem_ack  = i_mem_req && (wait_cnt == i_wait);
    // Off-ack data is the inverse of the last word, so a stale sample cannot pass
    assign o_mem_data = o_mem_ack ? mem[i_mem_addr[10:2]] : ~last_data;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || !i_mem_req || o_mem_ack) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
        if (i_rst) begin
            last_data <= 32'h0000_0000;
        end else if (o_mem_ack) begin
            last_data <= o_mem_data;
        end
    end
endmodule // uiv_mem_model

// *** verif/uiv_validator_tb.sv ***
// Self-checking bench for the update image validator.
// Assumes the memory model above; builds images in its array between runs.
`timescale 1ns/1ps
module uiv_validator_tb;
    localparam logic [31:0] SIG_VAL = 32'h0001_06A5;
    logic        i_clk_sys = 1'b0;
    logic        i_rst;
    logic        i_start;
    logic [31:0] i_cpu_signature;
    logic [2:0]  i_platform_field;
    logic        o_mem_req;
    logic [31:0] o_mem_addr;
    logic        i_mem_ack;
    logic [31:0] i_mem_data;
    logic        o_pass;
    logic        o_fail;
    logic        i_msr_rd;
    logic [31:0] i_msr_addr;
    logic        o_msr_ack;
    logic        o_msr_err;
    logic [63:0] o_msr_rdata;
    logic [3:0]  mem_wait;
    int          miscompares = 0;
    int          checks = 0;
    int          cycles = 0;

    uiv_validator dut_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(i_start),
        .i_cpu_signature(i_cpu_signature), .i_platform_field(i_platform_field),
        .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr), .i_mem_ack(i_mem_ack),
        .i_mem_data(i_mem_data), .o_pass(o_pass), .o_fail(o_fail), .i_msr_rd(i_msr_rd),
        .i_msr_addr(i_msr_addr), .o_msr_ack(o_msr_ack), .o_msr_err(o_msr_err),
        .o_msr_rdata(o_msr_rdata));
    uiv_mem_model part_u (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_mem_req(o_mem_req),
        .i_mem_addr(o_mem_addr), .i_wait(mem_wait), .o_mem_ack(i_mem_ack),
        .o_mem_data(i_mem_data));

    ////////////////////////////////////////////////////////////////////////////////
    always #5 i_clk_sys = ~i_clk_sys;

    task automatic stop_test();
        if (miscompares == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Longest run is about a thousand cycles; the ceiling leaves wide margin
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic cmp_bit(input logic act, input logic exp);
        checks++;
        if (act !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask

    task automatic cmp_word(input logic [63:0] act, input logic [63:0] exp);
        checks++;
        if (act !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t act=%h exp=%h", $time, act, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Image of 1024 bytes, or 2048 when data size is zero; extended entry at index hit carries the matching signature
    task automatic build(input logic [31:0] ver, dsz, psig, pflg, input int cnt, hit,
                         input logic [31:0] eflg, xbad, ibad);
        int          base;
        int          n;
        logic [31:0] s;
        for (int i = 0; i < 512; i++) part_u.mem[i] = i * 32'h9E37_79B9;
        part_u.mem[0] = ver;
        part_u.mem[3] = psig;
        part_u.mem[6] = pflg;
        part_u.mem[7] = 32'h0000_0400;
        part_u.mem[8] = dsz;
        base = int'(dsz[10:2]) + 12;
        part_u.mem[base] = 32'(cnt);
        for (int i = 1; i < 5; i++) part_u.mem[base + i] = 32'h0000_0000;
        for (int i = 0; i <= cnt; i++) begin
            part_u.mem[base + 5 + 3 * i] = (i == hit) ? SIG_VAL : SIG_VAL ^ 32'(i + 1);
            part_u.mem[base + 6 + 3 * i] = eflg;
        end
        s = xbad;
        for (int i = 0; i < 5 + 3 * cnt; i++) s = s - part_u.mem[base + i];
        part_u.mem[base + 1] = s;
        n = (dsz == 32'h0000_0000) ? 512 : 256;
        part_u.mem[4] = 32'h0000_0000;
        s = ibad;
        for (int i = 0; i < n; i++) s = s - part_u.mem[i];
        part_u.mem[4] = s;
    endtask

    task automatic run(input logic exp_pass);
        int k;
        @(negedge i_clk_sys) i_start = 1'b1;
        @(negedge i_clk_sys) i_start = 1'b0;
        k = 0;
        while (k < 3000 && (o_pass | o_fail) !== 1'b1) begin
            @(negedge i_clk_sys);
            k++;
        end
        cmp_bit(o_pass, exp_pass);
        cmp_bit(o_fail, !exp_pass);
        cmp_bit(o_mem_req, 1'b0);
    endtask

    task automatic msr(input logic [31:0] addr, input logic ok, input logic [63:0] exp);
        int k;
        @(negedge i_clk_sys) begin
            i_msr_rd = 1'b1;
            i_msr_addr = addr;
        end
        @(negedge i_clk_sys) i_msr_rd = 1'b0;
        k = 0;
        while (k < 2 && (o_msr_ack | o_msr_err) !== 1'b1) begin
            @(negedge i_clk_sys);
            k++;
        end
        cmp_bit(o_msr_ack, ok);
        cmp_bit(o_msr_err, !ok);
        cmp_word(o_msr_rdata, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_start = 1'b0;
        i_cpu_signature = SIG_VAL;
        i_platform_field = 3'h5;
        i_msr_rd = 1'b0;
        i_msr_addr = 32'h0000_0000;
        mem_wait = 4'h0;
        repeat (10) @(negedge i_clk_sys);
        i_rst = 1'b0;
        repeat (5) @(negedge i_clk_sys);
        msr(32'h0000_0017, 1'b1, {11'h000, 3'h5, 50'h0});
        msr(32'h0000_0018, 1'b0, {11'h000, 3'h5, 50'h0});
        msr(32'h0000_0016, 1'b0, {11'h000, 3'h5, 50'h0});
        build(32'h1, 32'h100, SIG_VAL, 32'h20, 0, 9, 32'h0, 32'h0, 32'h0);
        run(1'b1);
        mem_wait = 4'h3;
        run(1'b1);
        mem_wait = 4'h0;
        build(32'h2, 32'h100, SIG_VAL, 32'h20, 0, 9, 32'h0, 32'h0, 32'h0);
        run(1'b0);
        build(32'h1, 32'h100, SIG_VAL, 32'h20, 0, 9, 32'h0, 32'h0, 32'h1);
        run(1'b0);
        // A matching table sits just past the image, so only the size test can refuse it
        build(32'h1, 32'h3D0, SIG_VAL ^ 32'h1, 32'h20, 1, 0, 32'h20, 32'h0, 32'h0);
        run(1'b0);
        build(32'h1, 32'h100, SIG_VAL ^ 32'h1, 32'h0, 3, 2, 32'hFFFF_FF20, 32'h0, 32'h0);
        run(1'b1);
        build(32'h1, 32'h100, SIG_VAL ^ 32'h1, 32'h20, 3, 3, 32'h20, 32'h0, 32'h0);
        run(1'b0);
        build(32'h1, 32'h100, SIG_VAL ^ 32'h1, 32'h20, 0, 0, 32'h20, 32'h0, 32'h0);
        run(1'b0);
        build(32'h1, 32'h100, SIG_VAL ^ 32'h1, 32'h20, 3, 1, 32'h20, 32'h1, 32'h0);
        run(1'b0);
        build(32'h1, 32'h0, SIG_VAL, 32'h20, 0, 9, 32'h0, 32'h0, 32'h0);
        run(1'b1);
        // Reset in mid-walk must drop the request and clear the register data
        @(negedge i_clk_sys) i_start = 1'b1;
        @(negedge i_clk_sys) i_start = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        i_rst = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        i_rst = 1'b0;
        cmp_bit(o_mem_req, 1'b0);
        cmp_bit(o_pass, 1'b0);
        cmp_bit(o_fail, 1'b0);
        cmp_word(o_msr_rdata, 64'h0);
        run(1'b1);
        for (int p = 0; p < 8; p++) begin
            @(negedge i_clk_sys) i_platform_field = 3'(p);
            repeat (5) @(negedge i_clk_sys);
            msr(32'h0000_0017, 1'b1, {11'h000, 3'(p), 50'h0});
            build(32'h1, 32'h100, SIG_VAL, 32'h1 << p, 0, 9, 32'h0, 32'h0, 32'h0);
            run(1'b1);
            build(32'h1, 32'h100, SIG_VAL, ~(32'h1 << p), 0, 9, 32'h0, 32'h0, 32'h0);
            run(1'b0);
        end
        stop_test();
    end
endmodule // uiv_validator_tb
